// >>> trc_counter.sv
/*
  Dual 16-bit timer/event counter and RC-type converter counter pair.
  Assumes a CPU data memory port on sys_clk; all pins are asynchronous.
*/
module trc_counter
  import trc_pkg::*;
(
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  // Data memory port
  input  trc_pkg::trc_req_t   req,
  output logic [7:0]          rd_data,
  // Pins and oscillator outputs
  input  wire logic [7:0]     pins,
  // Configuration option: internal source is RTC oscillator
  input  wire logic           cfg_rtc_src,
  // Overflow flag
  input  wire logic           ovf_clr,
  output logic                overflow_flag,
  output logic                wake
);
  // ==========================================================
  // Pin synchronisers
  logic [PIN_N-1:0] s1_q, s2_q, s3_q;
  logic [PIN_N-1:0] rise, fall;

  // Two stages then an edge history stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  // ==========================================================
  // Registers and state
  logic [15:0] a_q, b_q;
  logic [7:0]  buf_q, rd_q;
  logic        run_q, edge_q, ovs_q, csel_q, flag_q, wake_q;
  logic [2:0]  mode_q;
  logic [3:0]  path_q;
  logic [1:0]  div_q;
  trc_pw_t     pw_q;

  // System clock divided by four
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) div_q <= '0;
    else       div_q <= div_q + 2'h1;
  end

  // ==========================================================
  // Clock selection
  logic tick4, osc_tick, a_tick, b_tick, act_edge, ret_edge;
  assign tick4 = (div_q == DIV4_LAST);

  // Oscillator path for counter B
  always_comb begin
    unique case (path_q)
      PATH_EXT:  osc_tick = rise[PIN_EXTC];
      PATH_RSCS: osc_tick = rise[PIN_REF];
      PATH_RTCS: osc_tick = rise[PIN_SRES];
      PATH_CRT:  osc_tick = rise[PIN_SRC];
      PATH_RSCR: osc_tick = rise[PIN_RSCR];
      default:   osc_tick = 1'b0;
    endcase
  end

  // Active and return edges on the event pin
  assign act_edge = edge_q ? fall[PIN_EVT] : rise[PIN_EVT];
  assign ret_edge = edge_q ? rise[PIN_EVT] : fall[PIN_EVT];

  // Counter A clock from the operating mode
  always_comb begin
    unique case (mode_q)
      MODE_SYS:  a_tick = cfg_rtc_src ? rise[PIN_RTCO] : 1'b1;
      MODE_DIV4: a_tick = tick4;
      MODE_RTC:  a_tick = rise[PIN_PRES];
      MODE_ADCK: a_tick = osc_tick;
      MODE_EVT:  a_tick = act_edge;
      MODE_PW:   a_tick = tick4 && (pw_q == PW_MEAS);
      default:   a_tick = 1'b0;
    endcase
  end
  assign b_tick = osc_tick;

  // ==========================================================
  // Access decode
  logic acc_a, acc_b, blk, ok;
  logic wr_ahi, wr_bhi, wr_lo, rd_ahi, rd_bhi, wr_ctrl;
  logic [15:0] wr_word;
  assign acc_a = (req.addr == A_HI_ADDR) || (req.addr == A_LO_ADDR);
  assign acc_b = (req.addr == B_HI_ADDR) || (req.addr == B_LO_ADDR);
  // Counter bytes serviced when stopped; preload writes also while timing
  assign ok = !run_q || (!csel_q && acc_b && req.wr);
  assign wr_ahi  = req.wr && ok && (req.addr == A_HI_ADDR);
  assign wr_bhi  = req.wr && ok && (req.addr == B_HI_ADDR);
  assign wr_lo   = req.wr && ok &&
                   ((req.addr == A_LO_ADDR) || (req.addr == B_LO_ADDR));
  assign rd_ahi  = req.rd && ok && (req.addr == A_HI_ADDR);
  assign rd_bhi  = req.rd && ok && (req.addr == B_HI_ADDR);
  assign wr_ctrl = req.wr && (req.addr == CTRL_ADDR);
  assign wr_word = {req.wdata, buf_q};
  assign blk = req.rd && ((req.addr == A_HI_ADDR) || (req.addr == B_HI_ADDR));

  // ==========================================================
  // Counting and overflow
  logic a_inc, b_inc, a_ovf, b_ovf, t_ovf, c_stop, pw_done;
  assign a_inc = run_q && !blk && a_tick;
  assign b_inc = run_q && !blk && b_tick && csel_q;
  assign a_ovf = a_inc && (a_q == CNT_MAX);
  assign b_ovf = b_inc && (b_q == CNT_MAX);
  assign t_ovf = !csel_q && a_ovf;
  assign c_stop = csel_q && (ovs_q ? b_ovf : a_ovf);
  assign pw_done = run_q && !csel_q && (mode_q == MODE_PW) &&
                   (pw_q == PW_MEAS) && ret_edge;

  // Counter A: load, reload, count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) a_q <= '0;
    else if (wr_ahi) a_q <= wr_word;
    else if (wr_bhi && !csel_q && !run_q) a_q <= wr_word;
    else if (t_ovf) a_q <= b_q;
    else if (a_inc) a_q <= a_q + 16'h0001;
  end

  // Counter B, or preload in timer use
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) b_q <= '0;
    else if (wr_bhi) b_q <= wr_word;
    else if (b_inc) b_q <= b_q + 16'h0001;
  end

  // Shared low byte buffer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) buf_q <= '0;
    else if (wr_lo) buf_q <= req.wdata;
    else if (rd_ahi) buf_q <= a_q[7:0];
    else if (rd_bhi) buf_q <= b_q[7:0];
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= CTRL_RST[MODE_LSB+:3];
      edge_q <= CTRL_RST[EDGE_BIT];
    end else if (wr_ctrl) begin
      mode_q <= req.wdata[MODE_LSB+:3];
      edge_q <= req.wdata[EDGE_BIT];
    end
  end

  // Run bit: software write, hardware stop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) run_q <= CTRL_RST[RUN_BIT];
    else if (wr_ctrl) run_q <= req.wdata[RUN_BIT];
    else if (c_stop || pw_done) run_q <= 1'b0;
  end

  // Converter control register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      path_q <= CONV_RST[PATH_LSB+:4];
      csel_q <= CONV_RST[CSEL_BIT];
      ovs_q  <= CONV_RST[OVS_BIT];
    end else if (req.wr && (req.addr == CONV_ADDR)) begin
      path_q <= req.wdata[PATH_LSB+:4];
      csel_q <= req.wdata[CSEL_BIT];
      ovs_q  <= req.wdata[OVS_BIT];
    end
  end

  // ==========================================================
  // Pulse width measurement sequence
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) pw_q <= PW_WAIT;
    else if (wr_ctrl) pw_q <= PW_WAIT;
    else begin
      unique case (pw_q)
        PW_WAIT: if (run_q && mode_q == MODE_PW && act_edge) pw_q <= PW_MEAS;
        PW_MEAS: if (!run_q || pw_done) pw_q <= PW_HOLD;
        PW_HOLD: pw_q <= PW_HOLD;
      endcase
    end
  end

  // ==========================================================
  // Overflow flag (set wins over clear) and wake pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      if (t_ovf || c_stop) flag_q <= 1'b1;
      else if (ovf_clr) flag_q <= 1'b0;
      wake_q <= a_ovf || b_ovf;
    end
  end

  // ==========================================================
  // Read data, registered
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rd_q <= '0;
    else if (req.rd) begin
      if (req.addr == CTRL_ADDR)
        rd_q <= {mode_q, run_q, edge_q, 3'h0} & CTRL_RMASK;
      else if (req.addr == CONV_ADDR)
        rd_q <= {path_q, 2'h0, csel_q, ovs_q} & CONV_RMASK;
      else if (rd_ahi) rd_q <= a_q[15:8];
      else if (rd_bhi) rd_q <= b_q[15:8];
      else if ((acc_a || acc_b) && ok) rd_q <= buf_q;
      else rd_q <= 8'h00;
    end
  end

  assign rd_data       = rd_q;
  assign overflow_flag = flag_q;
  assign wake          = wake_q;

  // ==========================================================
  // Assertions
  sequence s_pw_end;
    pw_done ##1 !run_q;
  endsequence

  a_timer_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
    t_ovf && !wr_ahi && !wr_bhi |=> a_q == $past(b_q))
    else $error("timer overflow did not reload");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    (t_ovf || c_stop) |=> overflow_flag)
    else $error("overflow flag not set");
  a_conv_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    c_stop && !wr_ctrl |=> !run_q && overflow_flag)
    else $error("converter overflow did not stop");
  a_read_block: assert property (@(posedge sys_clk) disable iff (!rstn)
    blk && !req.wr |=> a_q == $past(a_q))
    else $error("count moved during high read");
  a_stop_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_bhi && !csel_q && !run_q |=> a_q == $past(wr_word))
    else $error("stopped preload not copied");
  a_run_preload: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_bhi && run_q && !t_ovf |=> b_q == $past(wr_word) &&
    (a_q == $past(a_q) + 16'h0001 || a_q == $past(a_q)))
    else $error("running preload touched counter");
  a_buf_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_ahi |=> buf_q == $past(a_q[7:0]))
    else $error("high read did not latch low byte");
  a_conv_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    req.rd && req.addr == CONV_ADDR |=> rd_data[3:2] == 2'h0)
    else $error("unused converter bits not zero");
  a_pw_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    pw_done && !wr_ctrl |-> s_pw_end)
    else $error("pulse width did not clear run");
  a_wake_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    (a_ovf || b_ovf) |=> wake)
    else $error("no wake on overflow");
  a_stopped_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !run_q && !req.wr |=> a_q == $past(a_q))
    else $error("counter moved while stopped");

  // Single steps, refused reads and idle oscillator codes
  a_count_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    a_inc && !t_ovf && !req.wr |=> a_q == $past(a_q) + 16'h0001)
    else $error("counter did not step by one");
  a_refused_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    req.rd && run_q && (acc_a || acc_b) |=> rd_data == 8'h00)
    else $error("counter byte read while running");
  a_path_unused: assert property (@(posedge sys_clk) disable iff (!rstn)
    (path_q > PATH_RSCR) |-> !osc_tick)
    else $error("unused oscillator code clocked counter B");

  // Pulse width result kept after the measurement
  a_pw_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pw_q == PW_HOLD) && !req.wr |=> a_q == $past(a_q))
    else $error("pulse width result not held");
endmodule

// >>> trc_pkg.sv
/*
  Constants, codes and carrier types for the dual 16-bit counter block.
  Assumes one system clock domain and a byte-wide data memory port.
*/
package trc_pkg;
  // ==========================================================
  // Register byte addresses in data memory
  localparam logic [7:0] A_HI_ADDR = 8'h20;
  localparam logic [7:0] A_LO_ADDR = 8'h21;
  localparam logic [7:0] CTRL_ADDR = 8'h22;
  localparam logic [7:0] B_HI_ADDR = 8'h23;
  localparam logic [7:0] B_LO_ADDR = 8'h24;
  localparam logic [7:0] CONV_ADDR = 8'h25;
  // ==========================================================
  // Field positions
  localparam int EDGE_BIT = 3;
  localparam int RUN_BIT  = 4;
  localparam int MODE_LSB = 5;
  localparam int OVS_BIT  = 0;
  localparam int CSEL_BIT = 1;
  localparam int PATH_LSB = 4;
  localparam int INTC_OVF_BIT = 5;
  // ==========================================================
  // Reset values and readable masks
  localparam logic [7:0] CTRL_RST   = 8'h08;
  localparam logic [7:0] CONV_RST   = 8'h80;
  localparam logic [7:0] CTRL_RMASK = 8'hF8;
  localparam logic [7:0] CONV_RMASK = 8'hF3;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  // ==========================================================
  // Operating mode codes
  localparam logic [2:0] MODE_SYS  = 3'h0;
  localparam logic [2:0] MODE_DIV4 = 3'h1;
  localparam logic [2:0] MODE_RTC  = 3'h2;
  localparam logic [2:0] MODE_ADCK = 3'h3;
  localparam logic [2:0] MODE_EVT  = 3'h4;
  localparam logic [2:0] MODE_PW   = 3'h5;
  // Oscillator path codes
  localparam logic [3:0] PATH_EXT  = 4'h0;
  localparam logic [3:0] PATH_RSCS = 4'h1;
  localparam logic [3:0] PATH_RTCS = 4'h2;
  localparam logic [3:0] PATH_CRT  = 4'h3;
  localparam logic [3:0] PATH_RSCR = 4'h4;
  // ==========================================================
  // Pin vector indices
  localparam int PIN_EVT  = 0;
  localparam int PIN_EXTC = 1;
  localparam int PIN_REF  = 2;
  localparam int PIN_SRES = 3;
  localparam int PIN_SRC  = 4;
  localparam int PIN_RSCR = 5;
  localparam int PIN_RTCO = 6;
  localparam int PIN_PRES = 7;
  localparam int PIN_N    = 8;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {PW_WAIT, PW_MEAS, PW_HOLD} trc_pw_t;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } trc_req_t;
endpackage

// >>> trc_far_side.sv
/*
  Far-side model: event pin and RC oscillator sources of the block.
  Assumes the bench sets the event level and the oscillator enable.
*/
module trc_far_side (
  // Bench controls
  input  wire logic       evt_lvl,
  input  wire logic       osc_en,
  // Pins toward the block
  output logic [7:0]      pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic osc_q = 1'b0;
  // ==========================================================
  // RC oscillator, phase unrelated to sys_clk, still when off
  always #170 if (osc_en) osc_q = ~osc_q;
  // Event level straight through, all RC paths share one source
  assign pins = {2'b00, {5{osc_q}}, evt_lvl};
endmodule

// >>> tb_trc_counter.sv
/*
  Self-checking bench for the dual counter block.
  Assumes trc_pkg, trc_counter and trc_far_side are compiled first.
*/
module tb_trc_counter;
  import trc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  trc_req_t    req = '0;
  logic [7:0]  rd_data;
  logic [7:0]  pins;
  logic        ovf_clr = 1'b0;
  logic        overflow_flag;
  logic        wake;
  logic        evt_lvl = 1'b0;
  logic        osc_en = 1'b0;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          wakes = 0;
  int          n;
  logic [15:0] v;
  logic [15:0] e;
  // ==========================================================
  // Clock, timeout and wake pulse count
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end
  trc_counter dut_u (.sys_clk(sys_clk), .rstn(rstn), .req(req), .rd_data(rd_data),
    .pins(pins), .cfg_rtc_src(1'b0), .ovf_clr(ovf_clr),
    .overflow_flag(overflow_flag), .wake(wake));
  trc_far_side far_u (.evt_lvl(evt_lvl), .osc_en(osc_en), .pins(pins));
  // ==========================================================
  // Bus cycles, driven on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk);
    req = '0;
    d = rd_data;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // 16-bit load: low byte to buffer, then high byte
  task automatic ld16(input logic [7:0] hi, input logic [15:0] d);
    wr(hi + 8'h01, d[7:0]);
    wr(hi, d[15:8]);
  endtask
  task automatic rd16(input logic [7:0] hi, output logic [15:0] d);
    rd(hi, d[15:8]);
    rd(hi + 8'h01, d[7:0]);
  endtask
  task automatic wait_flag(input int lim);
    for (int i = 0; i < lim && overflow_flag !== 1'b1; i++) @(negedge sys_clk);
  endtask
  // Expected control byte from its fields
  function automatic logic [7:0] ctrl_b(input logic [2:0] m, input logic r, input logic e);
    return {m, r, e, 3'b000};
  endfunction
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(62));
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    rd(CTRL_ADDR, v[7:0]);
    chk("ctrl reset", {8'h00, CTRL_RST}, {8'h00, v[7:0]});
    wr(CONV_ADDR, 8'hFF);
    rd(CONV_ADDR, v[7:0]);
    chk("conv bits 3:2", 16'h00F3, {8'h00, v[7:0]});
    wr(CONV_ADDR, 8'h00);
    // Stopped preload write also loads counter A
    e = 16'($urandom);
    ld16(B_HI_ADDR, e);
    rd16(A_HI_ADDR, v);
    chk("preload to A", e, v);
    ld16(B_HI_ADDR, 16'hA5C3);
    rd16(A_HI_ADDR, v);
    chk("buffered low read", 16'hA5C3, v);
    // Event count on a randomly chosen active edge, random pulse number
    n = 3 + ($urandom % 18);
    e = 16'($urandom);
    ld16(A_HI_ADDR, 16'h0000);
    wr(CTRL_ADDR, ctrl_b(MODE_EVT, 1'b1, e[0]));
    repeat (n) begin
      repeat (4) @(negedge sys_clk);
      evt_lvl = 1'b1;
      repeat (4) @(negedge sys_clk);
      evt_lvl = 1'b0;
    end
    repeat (6) @(negedge sys_clk);
    wr(CTRL_ADDR, ctrl_b(MODE_EVT, 1'b0, e[0]));
    rd16(A_HI_ADDR, v);
    chk("event count", 16'(n), v);
    // Timer overflow with preload changed while running
    ld16(B_HI_ADDR, 16'hFFF0);
    wr(CTRL_ADDR, ctrl_b(MODE_SYS, 1'b1, 1'b0));
    ld16(B_HI_ADDR, 16'h1234);
    wait_flag(40);
    chk("timer overflow flag", 16'h0001, {15'h0, overflow_flag});
    wr(CTRL_ADDR, ctrl_b(MODE_SYS, 1'b0, 1'b0));
    rd16(A_HI_ADDR, v);
    chk("reload near new preload", 16'h0001, {15'h0, v >= 16'h1234 && v < 16'h1244});
    chk("wake pulse", 16'h0001, 16'(wakes));
    @(negedge sys_clk);
    ovf_clr = 1'b1;
    @(negedge sys_clk);
    ovf_clr = 1'b0;
    @(negedge sys_clk);
    chk("flag cleared", 16'h0000, {15'h0, overflow_flag});
    // Unused mode holds A; counter bytes refused while running
    ld16(A_HI_ADDR, 16'h5555);
    wr(CTRL_ADDR, ctrl_b(3'h6, 1'b1, 1'b0));
    repeat (30) @(negedge sys_clk);
    rd(A_HI_ADDR, v[7:0]);
    chk("refused read", 16'h0000, {8'h00, v[7:0]});
    rd(CTRL_ADDR, v[7:0]);
    chk("run bit stays", {8'h00, ctrl_b(3'h6, 1'b1, 1'b0)}, {8'h00, v[7:0]});
    wr(CTRL_ADDR, ctrl_b(3'h6, 1'b0, 1'b0));
    rd16(A_HI_ADDR, v);
    chk("unused mode idle", 16'h5555, v);
    // Pulse width: one measurement, run cleared, second pulse ignored
    n = 20 + ($urandom % 40);
    ld16(A_HI_ADDR, 16'h0000);
    wr(CTRL_ADDR, ctrl_b(MODE_PW, 1'b1, 1'b0));
    repeat (2) begin
      repeat (6) @(negedge sys_clk);
      evt_lvl = 1'b1;
      repeat (n) @(negedge sys_clk);
      evt_lvl = 1'b0;
    end
    repeat (6) @(negedge sys_clk);
    rd(CTRL_ADDR, v[7:0]);
    chk("pw run cleared", {8'h00, ctrl_b(MODE_PW, 1'b0, 1'b0)}, {8'h00, v[7:0]});
    rd16(A_HI_ADDR, v);
    chk("pw width held", 16'h0001, {15'h0, v >= 16'(n / 4) && v <= 16'(n / 4 + 1)});
    // Converter: B overflow from RC path stops both counters
    wr(CONV_ADDR, {PATH_RSCS, 4'b0011});
    ld16(A_HI_ADDR, 16'h0000);
    ld16(B_HI_ADDR, 16'hFFF0);
    wr(CTRL_ADDR, ctrl_b(MODE_DIV4, 1'b1, 1'b0));
    osc_en = 1'b1;
    wait_flag(2000);
    chk("conv flag", 16'h0001, {15'h0, overflow_flag});
    repeat (40) @(negedge sys_clk);
    osc_en = 1'b0;
    rd(CTRL_ADDR, v[7:0]);
    chk("conv run cleared", {8'h00, ctrl_b(MODE_DIV4, 1'b0, 1'b0)}, {8'h00, v[7:0]});
    rd16(B_HI_ADDR, v);
    chk("B wrapped and stopped", 16'h0000, v);
    rd16(A_HI_ADDR, v);
    chk("A stopped below B span", 16'h0001, {15'h0, v < 16'h0100});
    // Converter: A overflow selected, B clocked from the external clock pin
    wr(CONV_ADDR, {PATH_EXT, 4'b0010});
    ld16(A_HI_ADDR, 16'hFFF0);
    ld16(B_HI_ADDR, 16'h0000);
    @(negedge sys_clk);
    ovf_clr = 1'b1;
    @(negedge sys_clk);
    ovf_clr = 1'b0;
    osc_en = 1'b1;
    wr(CTRL_ADDR, ctrl_b(MODE_SYS, 1'b1, 1'b0));
    wait_flag(100);
    chk("conv A flag", 16'h0001, {15'h0, overflow_flag});
    osc_en = 1'b0;
    rd16(A_HI_ADDR, v);
    chk("A wrapped and stopped", 16'h0000, v);
    rd16(B_HI_ADDR, v);
    chk("B counted external clock", 16'h0001, {15'h0, v != 16'h0000 && v < 16'h0010});
    wrap_up();
  end
endmodule
